// file: hw/rotate_set_map.svh
// Offsets, field positions, reset values and timing of the rotate and set datapath
//
// Summary of operation
// [RULE_01] Rotate-left-via-carry, opcode 0011 01da, moves source bit n into result bit n+1.
// [RULE_02] That rotate puts old carry in bit 0, old bit 7 in carry; updates C, N, Z.
// [RULE_03] Rotate-right-plain moves source bit n into result bit n-1; carry untouched.
// [RULE_04] Set-all-ones, pattern 0110 100a, writes FFh to the file register; flags unchanged.
// [RULE_05] Rotates write working register when destination bit is 0, file register when 1.
// [RULE_06] Access bit 0 selects the access bank; 1 selects the bank select register's bank.
// [RULE_07] One word, one cycle (return takes two): decode Q1, read Q2, process Q3, write Q4.
// [RULE_08] Return loads the program counter from the stack top value.
// [RULE_09] Rotate-right-plain moves bit 0 into bit 7; Z and N follow the result.
`ifndef ROTATE_SET_MAP_SVH
`define ROTATE_SET_MAP_SVH

// ==================================================
// Host port map
`define HOST_ADDR_W 13
`define CORE_SEL_BIT 12
`define OFS_INSTR 4'h0
`define OFS_WREG 4'h1
`define OFS_STATUS 4'h2
`define OFS_BANK 4'h3
`define OFS_PC 4'h4
`define OFS_STK 4'h5

// ==================================================
// Status bit positions
`define ST_CARRY 0
`define ST_ZERO 1
`define ST_NEG 2
`define ST_ILLEGAL 6
`define ST_BUSY 7

// ==================================================
// Instruction fields and encodings
`define F_DEST 9
`define F_ACCESS 8
`define ROTL_OPCODE 6'h0D
`define ROTR_OPCODE_DEF 6'h3E
`define ONES_OPCODE 7'h34
`define RET_OPCODE 15'h0009
`define SET_VALUE 8'hFF
`define FILE_ADDR_W 12
`define ACCESS_SPLIT_DEF 8'h80

// ==================================================
// Reset values and timing
`define PC_RST 16'h0000
`define STK_RST 16'h0000
`define WREG_RST 8'h00
`define BANK_RST 4'h0
`define PC_STEP 16'h0002
`define QUARTERS 4

`endif

// file: hw/rotate_set_pkg.sv
// Types shared by the rotate and set datapath
package rotate_set_pkg;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_ROT_LEFT_C = 3'b001,
    OP_ROT_RIGHT = 3'b010,
    OP_SET_ONES = 3'b011,
    OP_RETURN = 3'b100
  } op_kind_t;

endpackage

// file: hw/file_ram.sv
// Two-port file register memory with registered read data
`timescale 1ns/1ns
`default_nettype none

module file_ram #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 12
)
(
  input wire logic clk,
  input wire logic [ADDR_W-1:0] addrA,
  input wire logic weA,
  input wire logic [DATA_W-1:0] wdataA,
  output logic [DATA_W-1:0] rdataA,
  input wire logic [ADDR_W-1:0] addrB,
  input wire logic reB,
  input wire logic weB,
  input wire logic [DATA_W-1:0] wdataB,
  output logic [DATA_W-1:0] rdataB
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // Port A written last so the core wins a same-address clash
  always_ff @(posedge clk)
  begin
    if (weB)
      mem[addrB] <= wdataB;
    if (weA)
      mem[addrA] <= wdataA;
  end

  always_ff @(posedge clk)
  begin
    rdataA <= mem[addrA];
  end

  always_ff @(posedge clk)
  begin
    if (reB)
      rdataB <= mem[addrB];
  end

endmodule // file_ram

`default_nettype wire

// file: hw/rotate_and_set_file_exec.sv
// Execution datapath for rotate, set-all-ones and return instructions
`timescale 1ns/1ns
`default_nettype none
`include "rotate_set_map.svh"

module rotate_and_set_file_exec #(
  parameter int ADDR_W = `FILE_ADDR_W,
  parameter logic [5:0] ROTR_OPCODE = `ROTR_OPCODE_DEF,
  parameter logic [7:0] ACCESS_SPLIT = `ACCESS_SPLIT_DEF
)
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [`HOST_ADDR_W-1:0] hostAddr,
  input wire logic [15:0] hostWdata,
  input wire logic hostWr,
  input wire logic hostRd,
  output logic [15:0] hostRdata,
  output logic [15:0] programCounter,
  output logic busy
);

  localparam int BANK_W = ADDR_W - 8;

  // ==================================================
  // Elaboration checks
  if (ADDR_W < 9 || ADDR_W > 12)
  begin : gAddrCheck
    $error("ADDR_W must lie between 9 and 12");
  end
  if (ROTR_OPCODE == `ROTL_OPCODE || ROTR_OPCODE == `ONES_OPCODE >> 1 || ROTR_OPCODE == 6'h00)
  begin : gOpcodeCheck
    $error("ROTR_OPCODE collides with another encoding");
  end

  // ==================================================
  // Reset release
  logic rstMeta_reg;
  logic syncRst_b;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_reg <= 1'b0;
      syncRst_b <= 1'b0;
    end
    else
    begin
      rstMeta_reg <= 1'b1;
      syncRst_b <= rstMeta_reg;
    end
  end

  // ==================================================
  // State
  rotate_set_pkg::phase_t phase_reg;
  rotate_set_pkg::phase_t phase_next;
  rotate_set_pkg::op_kind_t kindDecoded;
  rotate_set_pkg::op_kind_t opKind_reg;
  logic [15:0] instr_reg;
  logic [15:0] opWord_reg;
  logic pending_reg;
  logic active_reg;
  logic secondCycle_reg;
  logic [7:0] srcReg_reg;
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic [7:0] wReg_reg;
  logic carry_reg;
  logic zero_reg;
  logic neg_reg;
  logic illegal_reg;
  logic [3:0] bankSelect_reg;
  logic [15:0] programCounter_reg;
  logic [15:0] stackTopValue_reg;
  logic [ADDR_W-1:0] memAddr;
  logic [7:0] memRdata;
  logic [7:0] hostMemRdata;
  logic [BANK_W-1:0] bankUsed;
  logic memWe;
  logic exec;
  logic lastQuarter;
  logic isRotate;
  logic toFile;
  logic hostCoreWr;
  logic hostMemSel;
  logic wrInstr;
  logic [3:0] hostIdx;
  logic [15:0] coreRd_reg;
  logic rdMem_reg;
  logic rdValid_reg;

  assign exec = active_reg && !secondCycle_reg;
  assign lastQuarter = phase_reg == rotate_set_pkg::PH_Q4;
  assign isRotate = opKind_reg == rotate_set_pkg::OP_ROT_LEFT_C
    || opKind_reg == rotate_set_pkg::OP_ROT_RIGHT;
  assign toFile = opWord_reg[`F_DEST];
  assign hostIdx = hostAddr[3:0];
  assign hostMemSel = !hostAddr[`CORE_SEL_BIT];
  assign hostCoreWr = hostWr && !hostMemSel;
  assign busy = pending_reg || active_reg;
  assign wrInstr = hostCoreWr && hostIdx == `OFS_INSTR && !busy;
  assign programCounter = programCounter_reg;

  // ==================================================
  // Quarter phase sequencer
  always_comb
  begin
    case (phase_reg)
      rotate_set_pkg::PH_Q1: phase_next = rotate_set_pkg::PH_Q2;
      rotate_set_pkg::PH_Q2: phase_next = rotate_set_pkg::PH_Q3;
      rotate_set_pkg::PH_Q3: phase_next = rotate_set_pkg::PH_Q4;
      default: phase_next = rotate_set_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge core_clk or negedge syncRst_b)
  begin
    if (!syncRst_b)
      phase_reg <= rotate_set_pkg::PH_Q1;
    else
      phase_reg <= phase_next; // RULE_07
  end

  // ==================================================
  // Decode
  always_comb
  begin
    kindDecoded = rotate_set_pkg::OP_NONE;
    if (instr_reg[15:10] == `ROTL_OPCODE)
      kindDecoded = rotate_set_pkg::OP_ROT_LEFT_C; // RULE_01
    else if (instr_reg[15:10] == ROTR_OPCODE)
      kindDecoded = rotate_set_pkg::OP_ROT_RIGHT; // RULE_03
    else if (instr_reg[15:9] == `ONES_OPCODE)
      kindDecoded = rotate_set_pkg::OP_SET_ONES; // RULE_04
    else if (instr_reg[15:1] == `RET_OPCODE)
      kindDecoded = rotate_set_pkg::OP_RETURN; // RULE_08
  end

  // Instruction launch; a write while busy is dropped, software polls busy
  always_ff @(posedge core_clk or negedge syncRst_b)
  begin
    if (!syncRst_b)
    begin
      pending_reg <= 1'b0;
      instr_reg <= 16'h0000;
    end
    else if (wrInstr)
    begin
      pending_reg <= 1'b1;
      instr_reg <= hostWdata;
    end
    else if (pending_reg && phase_reg == rotate_set_pkg::PH_Q1)
      pending_reg <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge syncRst_b)
  begin
    if (!syncRst_b)
    begin
      active_reg <= 1'b0;
      secondCycle_reg <= 1'b0;
      opKind_reg <= rotate_set_pkg::OP_NONE;
      opWord_reg <= 16'h0000;
    end
    else if (pending_reg && phase_reg == rotate_set_pkg::PH_Q1)
    begin
      active_reg <= 1'b1; // RULE_07
      opKind_reg <= kindDecoded;
      opWord_reg <= instr_reg;
    end
    else if (lastQuarter && active_reg)
    begin
      // Return takes a second, idle instruction cycle
      if (exec && opKind_reg == rotate_set_pkg::OP_RETURN)
        secondCycle_reg <= 1'b1;
      else
      begin
        active_reg <= 1'b0;
        secondCycle_reg <= 1'b0;
      end
    end
  end

  // ==================================================
  // Address resolution
  always_comb
  begin
    if (opWord_reg[`F_ACCESS])
      bankUsed = bankSelect_reg[BANK_W-1:0]; // RULE_06
    else if (opWord_reg[7:0] >= ACCESS_SPLIT)
      bankUsed = '1; // RULE_06
    else
      bankUsed = '0; // RULE_06
  end

  assign memAddr = {bankUsed, opWord_reg[7:0]};
  assign memWe = exec && lastQuarter
    && (opKind_reg == rotate_set_pkg::OP_SET_ONES || (isRotate && toFile)); // RULE_05

  file_ram #(
    .DATA_W(8),
    .ADDR_W(ADDR_W)
  ) fileMem (
    .clk(core_clk),
    .addrA(memAddr),
    .weA(memWe),
    .wdataA(result_reg),
    .rdataA(memRdata),
    .addrB(hostAddr[ADDR_W-1:0]),
    .reB(hostRd && hostMemSel),
    .weB(hostWr && hostMemSel),
    .wdataB(hostWdata[7:0]),
    .rdataB(hostMemRdata)
  );

  // ==================================================
  // Process data in Q3
  always_comb
  begin
    case (opKind_reg)
      rotate_set_pkg::OP_ROT_LEFT_C: result_next = {memRdata[6:0], carry_reg}; // RULE_01
      rotate_set_pkg::OP_ROT_RIGHT: result_next = {memRdata[0], memRdata[7:1]}; // RULE_09
      rotate_set_pkg::OP_SET_ONES: result_next = `SET_VALUE; // RULE_04
      default: result_next = memRdata;
    endcase
  end

  always_ff @(posedge core_clk or negedge syncRst_b)
  begin
    if (!syncRst_b)
    begin
      srcReg_reg <= 8'h00;
      result_reg <= 8'h00;
    end
    else if (exec && phase_reg == rotate_set_pkg::PH_Q3)
    begin
      srcReg_reg <= memRdata;
      result_reg <= result_next;
    end
  end

  // ==================================================
  // Write back in Q4; the core beats a host write in the same cycle
  always_ff @(posedge core_clk or negedge syncRst_b)
  begin
    if (!syncRst_b)
      wReg_reg <= `WREG_RST;
    else if (exec && lastQuarter && isRotate && !toFile)
      wReg_reg <= result_reg; // RULE_05
    else if (hostCoreWr && hostIdx == `OFS_WREG)
      wReg_reg <= hostWdata[7:0];
  end

  always_ff @(posedge core_clk or negedge syncRst_b)
  begin
    if (!syncRst_b)
    begin
      carry_reg <= 1'b0;
      zero_reg <= 1'b0;
      neg_reg <= 1'b0;
    end
    else if (exec && lastQuarter && isRotate)
    begin
      if (opKind_reg == rotate_set_pkg::OP_ROT_LEFT_C)
        carry_reg <= srcReg_reg[7]; // RULE_02
      zero_reg <= result_reg == 8'h00; // RULE_02 RULE_09
      neg_reg <= result_reg[7]; // RULE_02 RULE_09
    end
    else if (hostCoreWr && hostIdx == `OFS_STATUS)
    begin
      carry_reg <= hostWdata[`ST_CARRY];
      zero_reg <= hostWdata[`ST_ZERO];
      neg_reg <= hostWdata[`ST_NEG];
    end
  end

  // Undecoded words: sticky flag, write one to clear, a new set wins
  always_ff @(posedge core_clk or negedge syncRst_b)
  begin
    if (!syncRst_b)
      illegal_reg <= 1'b0;
    else if (exec && lastQuarter && opKind_reg == rotate_set_pkg::OP_NONE)
      illegal_reg <= 1'b1;
    else if (hostCoreWr && hostIdx == `OFS_STATUS && hostWdata[`ST_ILLEGAL])
      illegal_reg <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge syncRst_b)
  begin
    if (!syncRst_b)
      programCounter_reg <= `PC_RST;
    else if (exec && lastQuarter)
    begin
      if (opKind_reg == rotate_set_pkg::OP_RETURN)
        programCounter_reg <= stackTopValue_reg; // RULE_08
      else
        programCounter_reg <= programCounter_reg + `PC_STEP; // RULE_07
    end
    else if (hostCoreWr && hostIdx == `OFS_PC)
      programCounter_reg <= hostWdata;
  end

  always_ff @(posedge core_clk or negedge syncRst_b)
  begin
    if (!syncRst_b)
    begin
      bankSelect_reg <= `BANK_RST;
      stackTopValue_reg <= `STK_RST;
    end
    else
    begin
      if (hostCoreWr && hostIdx == `OFS_BANK)
        bankSelect_reg <= hostWdata[3:0];
      if (hostCoreWr && hostIdx == `OFS_STK)
        stackTopValue_reg <= hostWdata;
    end
  end

  // ==================================================
  // Host read path, data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge syncRst_b)
  begin
    if (!syncRst_b)
    begin
      coreRd_reg <= 16'h0000;
      rdMem_reg <= 1'b0;
      rdValid_reg <= 1'b0;
    end
    else
    begin
      rdValid_reg <= hostRd;
      rdMem_reg <= hostRd && hostMemSel;
      coreRd_reg <= 16'h0000;
      if (hostRd && !hostMemSel)
      begin
        case (hostIdx)
          `OFS_INSTR: coreRd_reg <= instr_reg;
          `OFS_WREG: coreRd_reg <= {8'h00, wReg_reg};
          `OFS_STATUS: coreRd_reg <= {8'h00, busy, illegal_reg, 3'b000,
            neg_reg, zero_reg, carry_reg};
          `OFS_BANK: coreRd_reg <= {12'h000, bankSelect_reg};
          `OFS_PC: coreRd_reg <= programCounter_reg;
          `OFS_STK: coreRd_reg <= stackTopValue_reg;
          default: coreRd_reg <= 16'h0000;
        endcase
      end
    end
  end

  assign hostRdata = !rdValid_reg ? 16'h0000 : rdMem_reg ? {8'h00, hostMemRdata} : coreRd_reg;

  // ==================================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!syncRst_b);

  logic q4Rotl;
  logic q4Rotr;
  logic q4Set;
  assign q4Rotl = exec && lastQuarter && opKind_reg == rotate_set_pkg::OP_ROT_LEFT_C;
  assign q4Rotr = exec && lastQuarter && opKind_reg == rotate_set_pkg::OP_ROT_RIGHT;
  assign q4Set = exec && lastQuarter && opKind_reg == rotate_set_pkg::OP_SET_ONES;

  rotl_shift_a: assert property (q4Rotl |-> result_reg == {srcReg_reg[6:0], carry_reg}) // RULE_01
    else $error("left rotate result wrong");
  rotl_carry_a: assert property (q4Rotl |=> carry_reg == $past(srcReg_reg[7])
    && zero_reg == ($past(result_reg) == 8'h00) && neg_reg == $past(result_reg[7])) // RULE_02
    else $error("left rotate flags wrong");
  rotr_shift_a: assert property (q4Rotr |-> result_reg[6:0] == srcReg_reg[7:1]
    ##1 carry_reg == $past(carry_reg)) // RULE_03
    else $error("right rotate shift or carry wrong");
  rotr_wrap_a: assert property (q4Rotr |-> result_reg[7] == srcReg_reg[0]
    ##1 (zero_reg == ($past(result_reg) == 8'h00) && neg_reg == $past(result_reg[7]))) // RULE_09
    else $error("right rotate wrap or flags wrong");
  set_ones_a: assert property (q4Set |-> memWe && result_reg == 8'hFF
    ##1 $stable({carry_reg, zero_reg, neg_reg})) // RULE_04
    else $error("set all ones wrong");
  dest_work_a: assert property (exec && lastQuarter && isRotate && !toFile |-> !memWe
    ##1 wReg_reg == $past(result_reg)) // RULE_05
    else $error("working register destination wrong");
  dest_file_a: assert property (exec && lastQuarter && isRotate && toFile
    |-> memWe ##1 $stable(wReg_reg)) // RULE_05
    else $error("file destination wrong");
  bank_select_a: assert property (memWe && opWord_reg[`F_ACCESS]
    |-> memAddr[ADDR_W-1:8] == bankSelect_reg[BANK_W-1:0]) // RULE_06
    else $error("banked address wrong");
  access_bank_a: assert property (memWe && !opWord_reg[`F_ACCESS] && opWord_reg[7:0] < ACCESS_SPLIT
    |-> memAddr[ADDR_W-1:8] == '0) // RULE_06
    else $error("access bank address wrong");
  one_cycle_a: assert property (pending_reg && phase_reg == rotate_set_pkg::PH_Q1
    && kindDecoded != rotate_set_pkg::OP_RETURN |=> active_reg[*3] ##1 !active_reg) // RULE_07
    else $error("instruction not done in one cycle");
  return_pc_a: assert property (exec && lastQuarter && opKind_reg == rotate_set_pkg::OP_RETURN
    |=> programCounter_reg == $past(stackTopValue_reg) ##[1:4] !active_reg) // RULE_08
    else $error("return did not load stack top");

  rotl_cov: cover property (q4Rotl && !toFile);
  rotr_cov: cover property (q4Rotr && toFile);
  set_cov: cover property (q4Set && !opWord_reg[`F_ACCESS]);
  return_cov: cover property (exec && lastQuarter && opKind_reg == rotate_set_pkg::OP_RETURN);

endmodule // rotate_and_set_file_exec

`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the rotate, set-all-ones and return datapath
`timescale 1ns/1ns
`default_nettype none
`include "rotate_set_map.svh"

module tb_top;

  // ==================================================
  // Clock, reset and host port
  localparam logic [12:0] IN_AD = 13'h1000;
  localparam logic [12:0] W_AD = 13'h1001;
  localparam logic [12:0] ST_AD = 13'h1002;
  localparam logic [12:0] BK_AD = 13'h1003;
  localparam logic [12:0] STK_AD = 13'h1005;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [12:0] hostAddr = 13'h0000;
  logic [15:0] hostWdata = 16'h0000;
  logic hostWr = 1'b0;
  logic hostRd = 1'b0;
  logic [15:0] hostRdata;
  logic [15:0] programCounter;
  logic busy;
  int miscompares = 0;
  int samplesChecked = 0;
  logic [15:0] expPc = 16'h0000;
  logic [7:0] expW = 8'h00;
  logic [7:0] rlSrc [4] = '{8'hE6, 8'h80, 8'h80, 8'h7F};
  logic [7:0] rlRes [4] = '{8'hCC, 8'h01, 8'h00, 8'hFF};
  logic [2:0] rlFlg [4] = '{3'b101, 3'b001, 3'b011, 3'b100};
  logic [7:0] rrSrc [4] = '{8'hD7, 8'h00, 8'h01, 8'hFE};
  logic [7:0] rrRes [4] = '{8'hEB, 8'h00, 8'h80, 8'h7F};
  logic [2:0] rrFlg [4] = '{3'b100, 3'b011, 3'b100, 3'b001};
  logic [12:0] setHit [3] = '{13'h0210, 13'h0010, 13'h0F90};
  logic [12:0] setMiss [3] = '{13'h0010, 13'h0210, 13'h0290};
  logic [7:0] set_all_ones_op [3] = '{8'h10, 8'h10, 8'h90};

  always #50 core_clk = ~core_clk;

  rotate_and_set_file_exec rotate_and_set_file_exec_inst (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .hostAddr(hostAddr),
    .hostWdata(hostWdata),
    .hostWr(hostWr),
    .hostRd(hostRd),
    .hostRdata(hostRdata),
    .programCounter(programCounter),
    .busy(busy)
  );

  // ==================================================
  // Compare and report
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpBit(input logic got, input logic exp);
    samplesChecked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==================================================
  // Host accesses
  task automatic wr(input logic [12:0] a, input logic [15:0] d);
    @(posedge core_clk);
    hostWr <= 1'b1;
    hostAddr <= a;
    hostWdata <= d;
    @(posedge core_clk);
    hostWr <= 1'b0;
  endtask

  task automatic rdChk(input logic [12:0] a, input logic [15:0] exp, input logic [15:0] mask);
    @(posedge core_clk);
    hostRd <= 1'b1;
    hostAddr <= a;
    @(posedge core_clk);
    hostRd <= 1'b0;
    // Read data stands only in the cycle after the strobe
    @(negedge core_clk);
    cmp16(hostRdata & mask, exp);
  endtask

  task automatic waitIdle(input int limit);
    int n;
    n = 0;
    @(negedge core_clk);
    cmpBit(busy, 1'b1);
    while (busy !== 1'b0 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    cmpBit(n <= limit, 1'b1);
  endtask

  task automatic exec(input logic [15:0] word, input int limit, input logic [15:0] nextPc);
    wr(IN_AD, word);
    waitIdle(limit);
    expPc = nextPc;
    cmp16(programCounter, expPc);
  endtask

  task automatic rot(input logic [15:0] word, input logic [7:0] src, input logic cIn,
                     input logic [7:0] res, input logic [2:0] flags);
    wr({5'h00, word[7:0]}, {8'h00, src});
    wr(ST_AD, {15'h0000, cIn});
    exec(word, 7, expPc + `PC_STEP);
    if (!word[`F_DEST])
      expW = res;
    rdChk(W_AD, {8'h00, expW}, 16'h00FF);
    rdChk({5'h00, word[7:0]}, {8'h00, word[`F_DEST] ? res : src}, 16'h00FF);
    rdChk(ST_AD, {13'h0000, flags}, 16'h0007);
  endtask

  // ==================================================
  // Test sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    cmp16(programCounter, 16'h0000);
    cmpBit(busy, 1'b0);
    cmp16(hostRdata, 16'h0000);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdChk(W_AD, 16'h0000, 16'h00FF);
    for (int i = 0; i < 4; i++)
    begin
      rot({`ROTL_OPCODE, i[0], 1'b0, 8'h20 + 8'(i)}, rlSrc[i], i[0], rlRes[i],
          rlFlg[i]);
      rot({`ROTR_OPCODE_DEF, i[0], 1'b0, 8'h30 + 8'(i)}, rrSrc[i], i[0], rrRes[i],
          rrFlg[i]);
    end
    // Bank select stays 2 while the access bank is exercised
    wr(BK_AD, 16'h0002);
    wr(ST_AD, 16'h0005);
    for (int j = 0; j < 3; j++)
    begin
      wr(setHit[j], 16'h0000);
      wr(setMiss[j], 16'h0000);
      exec({`ONES_OPCODE, j == 0, set_all_ones_op[j]}, 7, expPc + `PC_STEP);
      rdChk(setHit[j], 16'h00FF, 16'h00FF);
      rdChk(setMiss[j], 16'h0000, 16'h00FF);
      rdChk(ST_AD, 16'h0005, 16'h0007);
    end
    // Second instruction while busy must be dropped
    wr(13'h0044, 16'h0000);
    wr(13'h0045, 16'h0000);
    @(posedge core_clk);
    hostWr <= 1'b1;
    hostAddr <= IN_AD;
    hostWdata <= {`ONES_OPCODE, 1'b0, 8'h44};
    @(posedge core_clk);
    hostWdata <= {`ONES_OPCODE, 1'b0, 8'h45};
    @(posedge core_clk);
    hostWr <= 1'b0;
    waitIdle(6);
    expPc = expPc + `PC_STEP;
    cmp16(programCounter, expPc);
    rdChk(13'h0044, 16'h00FF, 16'h00FF);
    rdChk(13'h0045, 16'h0000, 16'h00FF);
    exec(16'hFFFF, 7, expPc + `PC_STEP);
    rdChk(ST_AD, 16'h0040, 16'h0040);
    wr(STK_AD, 16'h0ABC);
    exec(16'h0012, 11, 16'h0ABC);
    wr(STK_AD, 16'h1234);
    exec(16'h0013, 11, 16'h1234);
    rdChk(IN_AD + 13'h0007, 16'h0000, 16'hFFFF);
    @(negedge core_clk);
    cmp16(hostRdata, 16'h0000);
    end_sim();
  end

  // ==================================================
  // Watchdog, far beyond the expected run of some 260 cycles
  initial
  begin
    repeat (10000) @(posedge core_clk);
    miscompares++;
    end_sim();
  end

endmodule // tb_top
`default_nettype wire
